// *** bench/tb_thermal_supervisor_register_bank.sv ***
`timescale 1ns/1ps
module tb_thermal_supervisor_register_bank;
  import thermal_supervisor_pkg::*;
  logic         ref_clk_in;
  logic         sys_rst_in;
  host_cmd_t    host_cmd;
  host_rsp_t    host_rsp;
  logic         conv_done;
  conv_result_t conv_result;
  logic         lockout;
  logic         conv_start;
  logic         conv_abort;
  logic         shutdown;
  logic [1:0]   resolution;
  logic         alert_n;
  logic         alert_oe;
  host_rsp_t    rsp;
  logic [7:0]   v;
  int           error_cnt = 0;
  int           checks = 0;
  int           start_cnt = 0;
  int           abort_cnt = 0;

  thermal_supervisor_register_bank u_thermal_supervisor_register_bank (
    .ref_clk_in            (ref_clk_in),
    .sys_rst_in            (sys_rst_in),
    .host_cmd_in           (host_cmd),
    .host_rsp_out          (host_rsp),
    .conv_done_in          (conv_done),
    .conv_result_in        (conv_result),
    .warm_reset_lockout_in (lockout),
    .conv_start_out        (conv_start),
    .conv_abort_out        (conv_abort),
    .shutdown_out          (shutdown),
    .remote_resolution_out (resolution),
    .alert_n_out           (alert_n),
    .alert_oe_out          (alert_oe)
  );

  thermal_host_model u_thermal_host_model (
    .ref_clk_in   (ref_clk_in),
    .host_rsp_in  (host_rsp),
    .host_cmd_out (host_cmd)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in)
  begin
    if (conv_start === 1'b1) start_cnt++;
    if (conv_abort === 1'b1) abort_cnt++;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] code);
    u_thermal_host_model.xfer(XFER_READ_BYTE, code, 8'h00, rsp);
    chk({16'h0, rsp.valid}, 17'h1);
    v = rsp.data[15:8];
  endtask

  task automatic rdx(input logic [7:0] code, input logic [7:0] exp);
    rd(code);
    chk({9'h0, v}, {9'h0, exp});
  endtask

  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    u_thermal_host_model.xfer(XFER_WRITE, code, data, rsp);
    chk({16'h0, rsp.valid}, 17'h1);
  endtask

  // settled alert pin, a few edges after its cause
  task automatic alert_is(input logic [1:0] exp);
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk({15'h0, alert_n, alert_oe}, {15'h0, exp});
  endtask

  // events: bits 6..3 limits, 2 diode fault, 1 remote overtemp, 0 local overtemp
  task automatic conv(input logic [7:0] lt, input logic [15:0] rt, input logic [6:0] ev);
    repeat (3) @(posedge ref_clk_in);
    #1;
    conv_result = {lt, rt, ev};
    conv_done = 1'b1;
    @(posedge ref_clk_in);
    #1;
    conv_done = 1'b0;
    conv_result = ~conv_result;
    repeat (3) @(posedge ref_clk_in);
  endtask

  task automatic t_reset();
    rdx(CMD_LOCAL_TEMP, 8'h00);
    rdx(CMD_REMOTE_HIGH, 8'h00);
    rdx(CMD_EVENT_FLAGS, 8'h00);
    rdx(CMD_SETUP, 8'h80);
    rdx(CMD_EVENT_MASK, 8'h07);
    rdx(8'h05, 8'h00);
    chk({15'h0, alert_n, alert_oe}, 17'h2);
  endtask

  task automatic t_results();
    wr(CMD_EVENT_MASK, 8'hff);
    conv(8'hf6, 16'h1aff, 7'h00);
    rdx(CMD_LOCAL_TEMP, 8'hf6);
    rdx(CMD_REMOTE_HIGH, 8'h1a);
    chk({16'h0, rsp.word}, 17'h0);
    u_thermal_host_model.xfer(XFER_READ_WORD, CMD_REMOTE_HIGH, 8'h00, rsp);
    chk({rsp.word, rsp.data}, {1'b1, 16'h1a80});
    u_thermal_host_model.xfer(XFER_READ_WORD, CMD_LOCAL_TEMP, 8'h00, rsp);
    chk({rsp.word, rsp.data}, {1'b0, 16'hf600});
    rdx(CMD_EVENT_MASK, 8'h7f);
    rdx(CMD_EVENT_FLAGS, 8'h80);
    rdx(CMD_EVENT_FLAGS, 8'h00);
  endtask

  task automatic t_resolution();
    for (int i = 0; i < 4; i++)
    begin
      wr(CMD_SETUP, 8'h80 | 8'(i << 2));
      conv(8'h00, 16'h55ff, 7'h00);
      chk({15'h0, resolution}, 17'(i));
      u_thermal_host_model.xfer(XFER_READ_WORD, CMD_REMOTE_HIGH, 8'h00, rsp);
      chk({rsp.word, rsp.data}, {1'b1, 8'h55, 8'(8'hff << (7 - i))});
    end
    wr(CMD_SETUP, 8'h80);
  endtask

  task automatic t_queue();
    int depth [4] = '{1, 2, 4, 6};
    for (int i = 0; i < 4; i++)
    begin
      wr(CMD_SETUP, 8'h80 | 8'(i << 4));
      repeat (depth[i] - 1) conv(8'h00, 16'h0, 7'h40);
      rd(CMD_EVENT_FLAGS);
      chk({16'h0, v[6]}, 17'h0);
      conv(8'h00, 16'h0, 7'h40);
      rd(CMD_EVENT_FLAGS);
      chk({16'h0, v[6]}, 17'h1);
    end
    wr(CMD_SETUP, 8'h80);
  endtask

  task automatic t_irq();
    wr(CMD_EVENT_MASK, 8'h07);
    conv(8'h00, 16'h0, 7'h04);
    alert_is(2'b01);
    wr(CMD_SETUP, 8'h00);
    alert_is(2'b10);
    wr(CMD_SETUP, 8'h80);
    alert_is(2'b01);
    rdx(CMD_EVENT_FLAGS, 8'h84);
    alert_is(2'b10);
    conv(8'h00, 16'h0, 7'h03);
    rdx(CMD_EVENT_FLAGS, 8'h83);
  endtask

  task automatic t_shutdown();
    int s0;
    conv(8'h00, 16'h0, 7'h01);
    alert_is(2'b01);
    wr(CMD_SETUP, 8'hc0);
    alert_is(2'b10);
    chk({16'h0, shutdown}, 17'h1);
    rdx(CMD_EVENT_FLAGS, 8'h00);
    rdx(CMD_SETUP, 8'hc0);
    rdx(CMD_EVENT_MASK, 8'h03);
    s0 = start_cnt;
    repeat (20) @(posedge ref_clk_in);
    chk(17'(start_cnt - s0), 17'h0);
    wr(CMD_SETUP, 8'h80);
  endtask

  task automatic t_warm_reset();
    conv(8'h2a, 16'h0, 7'h00);
    wr(CMD_EVENT_MASK, 8'h33);
    wr(CMD_SETUP, 8'h9c);
    lockout = 1'b1;
    wr(CMD_SETUP, 8'h9d);
    rdx(CMD_SETUP, 8'h9c);
    lockout = 1'b0;
    wr(CMD_SETUP, 8'h01);
    rdx(CMD_SETUP, 8'h80);
    rdx(CMD_EVENT_MASK, 8'h07);
    rdx(CMD_LOCAL_TEMP, 8'h00);
  endtask

  task automatic t_abort_ro();
    int a0;
    conv(8'h11, 16'h0, 7'h00);
    a0 = abort_cnt;
    wr(CMD_SETUP, 8'h80);
    repeat (2) @(posedge ref_clk_in);
    chk(17'(abort_cnt - a0), 17'h1);
    conv(8'h22, 16'h0, 7'h00);
    rdx(CMD_LOCAL_TEMP, 8'h22);
    wr(CMD_LOCAL_TEMP, 8'h55);
    rdx(CMD_LOCAL_TEMP, 8'h22);
    wr(CMD_EVENT_FLAGS, 8'h7f);
    rdx(CMD_EVENT_FLAGS, 8'h80);
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    sys_rst_in = 1'b1;
    conv_done = 1'b0;
    conv_result = '0;
    lockout = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_reset();
    t_results();
    t_resolution();
    t_queue();
    t_irq();
    t_shutdown();
    t_warm_reset();
    t_abort_ro();
    report_and_stop();
  end
endmodule

// *** bench/thermal_host_model.sv ***
`timescale 1ns/1ps
module thermal_host_model
(
  input  wire logic                              ref_clk_in,
  input  wire thermal_supervisor_pkg::host_rsp_t host_rsp_in,
  output      thermal_supervisor_pkg::host_cmd_t host_cmd_out
);
  import thermal_supervisor_pkg::*;

  initial host_cmd_out = '{XFER_NONE, 8'hff, 8'hff};

  // one request per call, held for exactly one taking edge
  task automatic xfer(input xfer_kind_t kind, input logic [7:0] code, input logic [7:0] data,
                      output host_rsp_t rsp);
    @(posedge ref_clk_in);
    #1;
    host_cmd_out.kind = kind;
    host_cmd_out.code = code;
    host_cmd_out.data = (code == CMD_SETUP) ? (data & 8'hfd) : data;
    @(posedge ref_clk_in);
    #1;
    // released fields flip so a stale value never passes for a request
    host_cmd_out = '{XFER_NONE, ~host_cmd_out.code, ~host_cmd_out.data};
    rsp = host_rsp_in;
  endtask
endmodule

// *** logic/thermal_supervisor_pkg.sv ***
package thermal_supervisor_pkg;
  // command bytes
  localparam logic [7:0] CMD_LOCAL_TEMP  = 8'h00;
  localparam logic [7:0] CMD_REMOTE_HIGH = 8'h01;
  localparam logic [7:0] CMD_EVENT_FLAGS = 8'h02;
  localparam logic [7:0] CMD_SETUP       = 8'h03;
  localparam logic [7:0] CMD_EVENT_MASK  = 8'h04;
  // reset values
  localparam logic [7:0] TEMP_RESET  = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET = 8'h80;
  localparam logic [7:0] MASK_RESET  = 8'h07;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // setup fields
  localparam int IRQ_EN_BIT   = 7;
  localparam int SHUTDOWN_BIT = 6;
  localparam int FQ_LSB       = 4;
  localparam int RES_LSB      = 2;
  localparam int WARM_RST_BIT = 0;
  // setup bits that read back (reserved bit 1 and write-only bit 0 read zero)
  localparam logic [7:0] SETUP_RD_MASK = 8'hfc;
  // flag positions
  localparam int DATA_READY_BIT  = 7;
  localparam int DIODE_FAULT_BIT = 2;
  localparam int REMOTE_OT_BIT   = 1;
  localparam int LOCAL_OT_BIT    = 0;
  localparam int LIMIT_LSB       = 3;
  localparam int NUM_LIMITS      = 4;
  // events that clear their own mask bit: data ready, limits, diode fault
  localparam logic [7:0] SELF_MASK_EVENTS = 8'hfc;
  // fault queue depths for codes 00..11
  localparam logic [2:0] FQ_DEPTH_0 = 3'h1;
  localparam logic [2:0] FQ_DEPTH_1 = 3'h2;
  localparam logic [2:0] FQ_DEPTH_2 = 3'h4;
  localparam logic [2:0] FQ_DEPTH_3 = 3'h6;
  // remote low byte fraction masks for 9..12 bit results
  localparam logic [7:0] RES_MASK_9  = 8'h80;
  localparam logic [7:0] RES_MASK_10 = 8'hc0;
  localparam logic [7:0] RES_MASK_11 = 8'he0;
  localparam logic [7:0] RES_MASK_12 = 8'hf0;

  typedef enum logic [1:0] {
    XFER_NONE      = 2'h0,
    XFER_READ_BYTE = 2'h1,
    XFER_READ_WORD = 2'h2,
    XFER_WRITE     = 2'h3
  } xfer_kind_t;

  typedef struct packed {
    xfer_kind_t  kind;
    logic [7:0]  code;
    logic [7:0]  data;
  } host_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        word;
    logic [15:0] data;
  } host_rsp_t;

  typedef struct packed {
    logic [7:0]            local_temp;
    logic [15:0]           remote_temp;
    logic [NUM_LIMITS-1:0] limit_cond;
    logic                  diode_fault;
    logic                  remote_ot;
    logic                  local_ot;
  } conv_result_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_SHUT = 3'b100
  } conv_state_t;
endpackage

// *** logic/thermal_supervisor_register_bank.sv ***
`timescale 1ns/1ps
// Operation
// - local result, command 00h, resets zero
// - results two's complement, one degree per lsb
// - local result zero until first conversion
// - byte read 01h returns remote high byte
// - word read 01h: high then low, atomic
// - only command 01h answers a word read
// - bit 7 set when new data ready
// - bits 6..0 flag the seven events
// - reading flags clears all eight bits
// - flags reset to 00h
// - setup bit 7 enables interrupt output
// - shutdown bit selects shutdown mode
// - resolution codes give 9 to 12 bits
// - warm reset restores power-up defaults
// - setup at 03h resets to 80h
// - setup write purges queues, restarts conversion
// - mask at 04h, one bit per flag
// - mask resets to 07h
// - non-overtemp event sets flag, clears mask
// - limit condition must persist queue-depth conversions
// - shutdown drops interrupt, clears flags, purges queues
// - lockout ignores the warm reset bit; the write still loads setup
module thermal_supervisor_register_bank
  import thermal_supervisor_pkg::*;
(
  input  wire logic                                 ref_clk_in,
  input  wire logic                                 sys_rst_in,
  input  wire thermal_supervisor_pkg::host_cmd_t    host_cmd_in,
  output      thermal_supervisor_pkg::host_rsp_t    host_rsp_out,
  input  wire logic                                 conv_done_in,
  input  wire thermal_supervisor_pkg::conv_result_t conv_result_in,
  input  wire logic                                 warm_reset_lockout_in,
  output      logic                                 conv_start_out,
  output      logic                                 conv_abort_out,
  output      logic                                 shutdown_out,
  output      logic [1:0]                           remote_resolution_out,
  output      logic                                 alert_n_out,
  output      logic                                 alert_oe_out
);
  import thermal_supervisor_pkg::*;

  logic [7:0]  local_temp_result_r;
  logic [7:0]  remote_temp_result_high_r;
  logic [7:0]  remote_temp_result_low_r;
  logic [7:0]  event_flags_r;
  logic [7:0]  operating_setup_r;
  logic [7:0]  event_mask_reg_r;
  conv_state_t conv_state_r;
  conv_state_t conv_state_nxt;
  logic        alert_r;
  logic [7:0]  irq_pend_r;

  logic        wr_any;
  logic        setup_wr;
  logic        warm_rst;
  logic        flags_rd;
  logic        result_take;
  logic        global_irq_enable;
  logic        shutdown_select;
  logic        shutdown_enter;
  logic        queue_purge;
  logic [1:0]  fault_queue_depth;
  logic [2:0]  fq_depth;
  logic [7:0]  low_mask;
  logic [7:0]  event_set;
  logic [NUM_LIMITS-1:0] limit_hit;

  assign wr_any            = host_cmd_in.kind == XFER_WRITE;
  assign setup_wr          = wr_any && host_cmd_in.code == CMD_SETUP;
  assign warm_rst          = setup_wr && host_cmd_in.data[WARM_RST_BIT]
                             && !warm_reset_lockout_in;
  assign flags_rd          = (host_cmd_in.kind == XFER_READ_BYTE
                             || host_cmd_in.kind == XFER_READ_WORD)
                             && host_cmd_in.code == CMD_EVENT_FLAGS;
  assign global_irq_enable = operating_setup_r[IRQ_EN_BIT];
  assign shutdown_select   = operating_setup_r[SHUTDOWN_BIT];
  assign fault_queue_depth = operating_setup_r[FQ_LSB +: 2];
  assign shutdown_enter    = setup_wr && !warm_rst && host_cmd_in.data[SHUTDOWN_BIT]
                             && !shutdown_select;
  // a result arriving with a setup write belongs to the aborted conversion
  assign result_take       = conv_done_in && conv_state_r == ST_BUSY && !setup_wr;
  assign queue_purge       = setup_wr || shutdown_select;

  always_comb
  begin
    case (fault_queue_depth)
      2'h0:    fq_depth = FQ_DEPTH_0;
      2'h1:    fq_depth = FQ_DEPTH_1;
      2'h2:    fq_depth = FQ_DEPTH_2;
      default: fq_depth = FQ_DEPTH_3;
    endcase
  end

  always_comb
  begin
    case (operating_setup_r[RES_LSB +: 2])
      2'h0:    low_mask = RES_MASK_9;
      2'h1:    low_mask = RES_MASK_10;
      2'h2:    low_mask = RES_MASK_11;
      default: low_mask = RES_MASK_12;
    endcase
  end

  // one fault queue per limit comparison; overtemperature and diode fault bypass it
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LIMITS; gi++)
    begin : g_queue
      logic [2:0] run_r;
      always_ff @(posedge ref_clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
          run_r <= 3'h0;
        else if (warm_rst || queue_purge)
          run_r <= 3'h0;
        else if (result_take)
        begin
          if (!conv_result_in.limit_cond[gi])
            run_r <= 3'h0;
          else if (run_r < fq_depth)
            run_r <= run_r + 3'h1;
        end
      end
      assign limit_hit[gi] = conv_result_in.limit_cond[gi]
                             && (run_r + 3'h1) >= fq_depth;
    end
  endgenerate

  always_comb
  begin
    event_set = 8'h00;
    if (result_take)
    begin
      event_set[DATA_READY_BIT]                  = 1'b1;
      event_set[LIMIT_LSB +: NUM_LIMITS]         = limit_hit;
      event_set[DIODE_FAULT_BIT]                 = conv_result_in.diode_fault;
      event_set[REMOTE_OT_BIT]                   = conv_result_in.remote_ot;
      event_set[LOCAL_OT_BIT]                    = conv_result_in.local_ot;
    end
  end

  // conversion sequencing
  always_comb
  begin
    conv_state_nxt = conv_state_r;
    case (conv_state_r)
      ST_IDLE:
        conv_state_nxt = shutdown_select ? ST_SHUT : ST_BUSY;
      ST_BUSY:
        if (setup_wr || conv_done_in)
          conv_state_nxt = ST_IDLE;
      ST_SHUT:
        if (!shutdown_select)
          conv_state_nxt = ST_IDLE;
      default:
        conv_state_nxt = ST_IDLE;
    endcase
    if (warm_rst)
      conv_state_nxt = ST_IDLE;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      conv_state_r   <= ST_IDLE;
      conv_start_out <= 1'b0;
      conv_abort_out <= 1'b0;
    end
    else
    begin
      conv_state_r   <= conv_state_nxt;
      conv_start_out <= conv_state_r == ST_IDLE && !shutdown_select && !warm_rst;
      conv_abort_out <= conv_state_r == ST_BUSY && (setup_wr || warm_rst);
    end
  end

  // result registers: both remote bytes load in one edge so a word read is atomic
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      local_temp_result_r       <= TEMP_RESET;
      remote_temp_result_high_r <= TEMP_RESET;
      remote_temp_result_low_r  <= TEMP_RESET;
    end
    else if (warm_rst)
    begin
      local_temp_result_r       <= TEMP_RESET;
      remote_temp_result_high_r <= TEMP_RESET;
      remote_temp_result_low_r  <= TEMP_RESET;
    end
    else if (result_take)
    begin
      // local and remote high bytes pass through unchanged; remote low byte masked by low_mask
      local_temp_result_r       <= conv_result_in.local_temp;
      remote_temp_result_high_r <= conv_result_in.remote_temp[15:8];
      remote_temp_result_low_r  <= conv_result_in.remote_temp[7:0] & low_mask;
    end
  end

  // flags: a new event wins over the read clear in the same edge
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      event_flags_r <= FLAGS_RESET;
    else if (warm_rst || shutdown_enter || shutdown_select)
      event_flags_r <= FLAGS_RESET;
    else if (flags_rd)
      event_flags_r <= event_set;
    else
      event_flags_r <= event_flags_r | event_set;
  end

  // self-masking events drop their mask as they set, so keep which ones were enabled
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      irq_pend_r <= FLAGS_RESET;
    else if (warm_rst || shutdown_enter || shutdown_select)
      irq_pend_r <= FLAGS_RESET;
    else if (flags_rd)
      irq_pend_r <= event_set & event_mask_reg_r;
    else
      irq_pend_r <= irq_pend_r | (event_set & event_mask_reg_r);
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      operating_setup_r <= SETUP_RESET;
    else if (warm_rst)
      operating_setup_r <= SETUP_RESET;
    else if (setup_wr)
      operating_setup_r <= host_cmd_in.data & SETUP_RD_MASK;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      event_mask_reg_r <= MASK_RESET;
    else if (warm_rst)
      event_mask_reg_r <= MASK_RESET;
    else if (wr_any && host_cmd_in.code == CMD_EVENT_MASK)
      event_mask_reg_r <= host_cmd_in.data & ~(event_set & SELF_MASK_EVENTS);
    else
      event_mask_reg_r <= event_mask_reg_r & ~(event_set & SELF_MASK_EVENTS);
  end

  // host answers: one cycle after the command, writes anywhere are acknowledged
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      host_rsp_out <= '0;
    else
    begin
      host_rsp_out.valid <= host_cmd_in.kind != XFER_NONE;
      host_rsp_out.word  <= host_cmd_in.kind == XFER_READ_WORD
                            && host_cmd_in.code == CMD_REMOTE_HIGH;
      case (host_cmd_in.code)
        CMD_LOCAL_TEMP:  host_rsp_out.data <= {local_temp_result_r, UNMAPPED_RD};
        CMD_REMOTE_HIGH: host_rsp_out.data <= {remote_temp_result_high_r,
                            remote_temp_result_low_r};
        CMD_EVENT_FLAGS: host_rsp_out.data <= {event_flags_r, UNMAPPED_RD};
        CMD_SETUP:       host_rsp_out.data <= {operating_setup_r, UNMAPPED_RD};
        CMD_EVENT_MASK:  host_rsp_out.data <= {event_mask_reg_r, UNMAPPED_RD};
        default:         host_rsp_out.data <= {UNMAPPED_RD, UNMAPPED_RD};
      endcase
    end
  end

  // status side outputs and the open-drain alert
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      alert_r               <= 1'b0;
      shutdown_out          <= 1'b0;
      remote_resolution_out <= 2'h0;
    end
    else
    begin
      alert_r               <= global_irq_enable && !shutdown_select
                               && |(event_flags_r & event_mask_reg_r | irq_pend_r);
      shutdown_out          <= shutdown_select;
      remote_resolution_out <= operating_setup_r[RES_LSB +: 2];
    end
  end

  // pin only ever sinks; the level driven while enabled is low
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      alert_n_out  <= 1'b1;
      alert_oe_out <= 1'b0;
    end
    else
    begin
      alert_n_out  <= !alert_r;
      alert_oe_out <= alert_r;
    end
  end

  setup_reset_a: assert property (@(posedge ref_clk_in)
    $fell(sys_rst_in) |-> operating_setup_r == SETUP_RESET && event_mask_reg_r == MASK_RESET)
    else $error("setup or mask not at power-up value");

  flags_clear_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    flags_rd && !result_take && !shutdown_select |=> event_flags_r == FLAGS_RESET)
    else $error("flags not cleared by read");

  read_value_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    flags_rd |=> host_rsp_out.data[15:8] == $past(event_flags_r))
    else $error("flags read returned wrong value");

  word_only_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    host_rsp_out.word |-> $past(host_cmd_in.code) == CMD_REMOTE_HIGH)
    else $error("word answer at wrong command");

  ready_sets_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    result_take && !warm_rst |=> event_flags_r[DATA_READY_BIT]
      && !event_mask_reg_r[DATA_READY_BIT])
    else $error("data ready did not set flag and clear mask");

  event_alert_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    global_irq_enable && !shutdown_select && |(event_set & event_mask_reg_r)
      |-> ##3 !alert_n_out && alert_oe_out)
    else $error("enabled event did not raise alert");

  atomic_pair_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $changed(remote_temp_result_low_r) |-> $past(result_take) || $past(warm_rst))
    else $error("low byte changed outside a conversion");

  alert_path_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    global_irq_enable && !shutdown_select && |(event_flags_r & event_mask_reg_r)
      |-> ##2 !alert_n_out && alert_oe_out)
    else $error("alert not driven for pending event");

  shutdown_quiet_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    shutdown_select |-> ##1 event_flags_r == FLAGS_RESET ##1 !alert_r)
    else $error("shutdown left flags or alert active");

  reset_lockout_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    setup_wr && warm_reset_lockout_in |=> operating_setup_r == ($past(host_cmd_in.data)
      & SETUP_RD_MASK))
    else $error("warm reset acted despite lockout");

  abort_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    conv_state_r == ST_BUSY && setup_wr |=> conv_abort_out ##1 conv_start_out
      || shutdown_select)
    else $error("setup write did not restart conversion");

  ro_write_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    wr_any && host_cmd_in.code == CMD_LOCAL_TEMP && !result_take && !warm_rst
      |=> $stable(local_temp_result_r) && host_rsp_out.valid)
    else $error("read-only write changed result");

  word_read_c:  cover property (@(posedge ref_clk_in) host_rsp_out.word);
  alert_c:      cover property (@(posedge ref_clk_in) alert_oe_out);
  queue_full_c: cover property (@(posedge ref_clk_in) result_take
                  && fault_queue_depth == 2'h3 && limit_hit[NUM_LIMITS-1]);
  warm_rst_c:   cover property (@(posedge ref_clk_in) warm_rst);
endmodule
